/* File: rtl/lan_cmd_pkg.sv */
/*
 * lan_cmd_pkg: register map, field layout, command and status codes and
 * timing counts for the mode-command decoder.
 * assumes: one 100 MHz clock, APB slave access with 32-bit data.
 */
package lan_cmd_pkg;

   // register byte offsets
   localparam logic [7:0] CTRL_STATUS_OFF = 8'h00;
   localparam logic [7:0] MODE_OFF        = 8'h04;
   localparam logic [7:0] LINK_OFF        = 8'h08;
   localparam logic [7:0] DIAG_OFF        = 8'h0C;

   // control_status_word field positions
   localparam int STATUS_LSB = 0;
   localparam int STATUS_W   = 4;
   localparam int DONE_BIT   = 7;
   localparam int FUNC_LSB   = 8;
   localparam int FUNC_W     = 6;

   // mode register bit positions
   localparam int PROMISC_BIT  = 0;
   localparam int RX_ERR_BIT   = 1;
   localparam int ONLINE_BIT   = 2;
   localparam int SRC_INS_BIT  = 3;
   localparam int LOOP_MOD_BIT = 4;
   localparam int LOOP_INT_BIT = 5;
   localparam int INDIC_BIT    = 6;
   localparam int DIAG_RUN_BIT = 7;

   // function codes (octal)
   localparam logic [5:0] FN_SET_LOOP_MOD = 6'o01;
   localparam logic [5:0] FN_SET_LOOP_INT = 6'o02;
   localparam logic [5:0] FN_CLR_LOOP     = 6'o03;
   localparam logic [5:0] FN_SET_PROMISC  = 6'o04;
   localparam logic [5:0] FN_CLR_PROMISC  = 6'o05;
   localparam logic [5:0] FN_SET_RX_ERR   = 6'o06;
   localparam logic [5:0] FN_CLR_RX_ERR   = 6'o07;
   localparam logic [5:0] FN_OFFLINE      = 6'o10;
   localparam logic [5:0] FN_ONLINE       = 6'o11;
   localparam logic [5:0] FN_DIAG         = 6'o12;
   localparam logic [5:0] FN_RSVD_A       = 6'o13;
   localparam logic [5:0] FN_RSVD_B       = 6'o14;
   localparam logic [5:0] FN_SET_SRC_INS  = 6'o15;
   localparam logic [5:0] FN_CLR_SRC_INS  = 6'o16;
   localparam logic [5:0] FN_TX_SEND      = 6'o51;
   localparam logic [5:0] FN_RESET        = 6'o77;

   // status codes
   localparam logic [3:0] ST_OK           = 4'h0;
   localparam logic [3:0] ST_ILLEGAL      = 4'h2;
   localparam logic [3:0] ST_INAPPROP     = 4'h3;

   // diagnostic run time
   localparam int DIAG_TIME_US   = 10;
   localparam int CLK_MHZ        = 100;
   localparam int DIAG_CYCLES    = DIAG_TIME_US * CLK_MHZ;
   localparam int DIAG_CNT_W     = 10;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_EXEC = 3'b010,
      ST_DIAG = 3'b100
   } cmd_state_e;

endpackage

/* File: rtl/lan_mode_command_decoder.sv */
/*
 * lan_mode_command_decoder: APB slave that takes function codes written to
 * the control_status_word, applies mode commands, and returns done/status.
 * assumes: APB master on pclk; receive/transmit datapaths outside this block
 * read the mode outputs and report frame-in-progress and diag results.
 */
// Decided for this implementation: the APB register port and the placing of the registers.
`timescale 1ns/1ps

module lan_mode_command_decoder
   import lan_cmd_pkg::*;
(
   // apb
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // datapath status
   input  wire logic        rx_frame_busy,
   input  wire logic        diag_done,
   input  wire logic [3:0]  diag_code,
   // mode outputs
   output logic             promisc_mode,
   output logic             rx_err_accept,
   output logic             online,
   output logic             src_insert,
   output logic             crc_gen_bypass,
   output logic             self_test_indicator,
   output logic             rx_flush,
   output logic             tx_flush,
   output logic             diag_start,
   output logic             tx_send_start
);
   import lan_cmd_pkg::*;

   cmd_state_e       state_ff;
   cmd_state_e       nxt_state;
   logic [5:0]       func_ff;
   logic [3:0]       status_ff;
   logic             done_ff;
   logic             promisc_ff;
   logic             rx_err_ff;
   logic             online_ff;
   logic             src_ins_ff;
   logic             loop_mod_ff;
   logic             loop_int_ff;
   logic             indic_ff;
   logic             off_pend_ff;
   logic [DIAG_CNT_W-1:0] diag_cnt_ff;
   logic             rx_busy_s1_ff;
   logic             rx_busy_s2_ff;
   logic             dd_s1_ff;
   logic             dd_s2_ff;
   logic             dd_s3_ff;
   logic [3:0]       dc_s1_ff;
   logic [3:0]       dc_s2_ff;
   logic             diag_hold_ff;
   logic [3:0]       diag_code_ff;
   logic [31:0]      prdata_ff;
   logic             pslverr_ff;
   logic             rx_flush_ff;
   logic             tx_flush_ff;
   logic             diag_start_ff;
   logic             tx_send_ff;
   logic             crc_byp_ff;

   // apb decode
   wire   acc        = psel & penable;
   wire   hit_csr    = (paddr == CTRL_STATUS_OFF);
   wire   hit_mode   = (paddr == MODE_OFF);
   wire   hit_link   = (paddr == LINK_OFF);
   wire   hit_diag   = (paddr == DIAG_OFF);
   wire   mapped     = hit_csr | hit_mode | hit_link | hit_diag;
   wire   csr_wr     = acc & pwrite & hit_csr & pstrb[1];
   // clear only when this read's captured word showed done, so a set that
   // lands on the setup edge is not lost before the host has seen it
   wire   csr_rd_lo  = acc & ~pwrite & hit_csr & prdata_ff[DONE_BIT];
   wire [5:0] wr_func = pwdata[FUNC_LSB +: FUNC_W];
   wire   is_reset   = csr_wr & (wr_func == FN_RESET);
   // host waits for done except for Reset; a write mid-command is dropped
   wire   take_cmd   = csr_wr & (state_ff == ST_IDLE) & ~is_reset;
   wire   any_loop   = loop_mod_ff | loop_int_ff;
   wire   diag_fin   = (state_ff == ST_DIAG) & dd_s2_ff & ~diag_hold_ff
                       & (diag_cnt_ff == '0);
   wire   exec_fin   = (state_ff == ST_EXEC);
   wire   cmd_fin    = exec_fin | diag_fin;
   wire   diag_pass  = (diag_code_ff == ST_OK);
   // a done still high from an earlier run shows no rising edge
   wire   dd_rise    = dd_s2_ff & ~dd_s3_ff;

   // status for a single-cycle command
   logic [3:0] exec_status;
   always_comb begin
      case (func_ff)
         FN_SET_LOOP_MOD, FN_SET_LOOP_INT, FN_CLR_LOOP,
         FN_SET_PROMISC, FN_CLR_PROMISC, FN_SET_RX_ERR, FN_CLR_RX_ERR,
         FN_OFFLINE, FN_ONLINE, FN_SET_SRC_INS, FN_CLR_SRC_INS:
            exec_status = ST_OK;
         FN_RSVD_A, FN_RSVD_B:
            exec_status = ST_OK;
         FN_TX_SEND:
            exec_status = online_ff ? ST_OK : ST_INAPPROP;
         default:
            exec_status = ST_ILLEGAL;
      endcase
   end

   always_comb begin
      case (state_ff)
         ST_IDLE: nxt_state = take_cmd ? ((wr_func == FN_DIAG) ? ST_DIAG : ST_EXEC)
                                       : ST_IDLE;
         ST_EXEC: nxt_state = ST_IDLE;
         ST_DIAG: nxt_state = diag_fin ? ST_IDLE : ST_DIAG;
         default: nxt_state = ST_IDLE;
      endcase
   end

   // pin-level inputs pass two flops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_busy_s1_ff <= 1'b0;
         rx_busy_s2_ff <= 1'b0;
         dd_s1_ff      <= 1'b0;
         dd_s2_ff      <= 1'b0;
         dd_s3_ff      <= 1'b0;
         dc_s1_ff      <= 4'h0;
         dc_s2_ff      <= 4'h0;
      end else begin
         rx_busy_s1_ff <= rx_frame_busy;
         rx_busy_s2_ff <= rx_busy_s1_ff;
         dd_s1_ff      <= diag_done;
         dd_s2_ff      <= dd_s1_ff;
         dd_s3_ff      <= dd_s2_ff;
         dc_s1_ff      <= diag_code;
         dc_s2_ff      <= dc_s1_ff;
      end
   end

   // diag code taken on the rising edge of synced done, travelling beside it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         diag_hold_ff <= 1'b1;
         diag_code_ff <= ST_OK;
         diag_cnt_ff  <= '0;
      end else if (take_cmd && wr_func == FN_DIAG) begin
         diag_hold_ff <= 1'b1;
         diag_cnt_ff  <= DIAG_CNT_W'(DIAG_CYCLES - 1);
      end else if (state_ff == ST_DIAG) begin
         if (diag_cnt_ff != '0)
            diag_cnt_ff <= diag_cnt_ff - 1'b1;
         if (dd_rise && diag_hold_ff) begin
            diag_hold_ff <= 1'b0;
            diag_code_ff <= dc_s2_ff;
         end
      end
   end

   // command sequencing, done and status
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_ff  <= ST_IDLE;
         func_ff   <= '0;
         status_ff <= ST_OK;
         done_ff   <= 1'b0;
      end else if (is_reset) begin
         state_ff  <= ST_EXEC;
         func_ff   <= FN_RESET;
         done_ff   <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         if (take_cmd)
            func_ff <= wr_func;
         // set wins over read-clear
         if (cmd_fin) begin
            done_ff   <= 1'b1;
            status_ff <= diag_fin ? diag_code_ff
                         : ((func_ff == FN_RESET) ? ST_OK : exec_status);
         end else if (csr_rd_lo) begin
            done_ff <= 1'b0;
         end
      end
   end

   wire do_reset  = exec_fin & (func_ff == FN_RESET);
   wire do_defaults = do_reset | (diag_fin & diag_pass);

   // mode flags, each held until a command or reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         promisc_ff  <= 1'b0;
         rx_err_ff   <= 1'b0;
         online_ff   <= 1'b0;
         src_ins_ff  <= 1'b1;
         loop_mod_ff <= 1'b0;
         loop_int_ff <= 1'b0;
         off_pend_ff <= 1'b0;
      end else if (do_defaults || (take_cmd && wr_func == FN_DIAG)) begin
         promisc_ff  <= 1'b0;
         rx_err_ff   <= 1'b0;
         online_ff   <= 1'b0;
         src_ins_ff  <= 1'b1;
         loop_mod_ff <= 1'b0;
         loop_int_ff <= 1'b0;
         off_pend_ff <= 1'b0;
      end else begin
         if (exec_fin) begin
            case (func_ff)
               FN_SET_PROMISC: promisc_ff <= 1'b1;
               FN_CLR_PROMISC: promisc_ff <= 1'b0;
               FN_SET_RX_ERR:  rx_err_ff  <= 1'b1;
               FN_CLR_RX_ERR:  rx_err_ff  <= 1'b0;
               FN_ONLINE: begin
                  online_ff   <= 1'b1;
                  off_pend_ff <= 1'b0;
               end
               FN_OFFLINE:
                  if (!any_loop)
                     off_pend_ff <= 1'b1;
               FN_SET_LOOP_MOD: begin
                  loop_mod_ff <= 1'b1;
                  online_ff   <= 1'b0;
               end
               FN_SET_LOOP_INT: begin
                  loop_int_ff <= 1'b1;
                  online_ff   <= 1'b0;
               end
               FN_CLR_LOOP: begin
                  loop_mod_ff <= 1'b0;
                  loop_int_ff <= 1'b0;
               end
               FN_SET_SRC_INS: src_ins_ff <= 1'b1;
               FN_CLR_SRC_INS: src_ins_ff <= 1'b0;
               default: ;
            endcase
         end
         // offline waits for the frame in reception to end
         if (off_pend_ff && !rx_busy_s2_ff) begin
            online_ff   <= 1'b0;
            off_pend_ff <= 1'b0;
         end
      end
   end

   // indicator: on in internal loopback and through diag, off on pass
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         indic_ff <= 1'b0;
      else if (take_cmd && wr_func == FN_DIAG)
         indic_ff <= 1'b1;
      else if (diag_fin)
         indic_ff <= ~diag_pass;
      else if (exec_fin && func_ff == FN_SET_LOOP_INT)
         indic_ff <= 1'b1;
      else if (exec_fin && (func_ff == FN_ONLINE || func_ff == FN_CLR_LOOP
                            || func_ff == FN_RESET))
         indic_ff <= 1'b0;
   end

   // one-cycle strobes and the crc bypass level to the datapath; transmit flush on diag start, reset and source-insertion changes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_flush_ff   <= 1'b0;
         tx_flush_ff   <= 1'b0;
         diag_start_ff <= 1'b0;
         tx_send_ff    <= 1'b0;
         crc_byp_ff    <= 1'b0;
      end else begin
         rx_flush_ff   <= (take_cmd && wr_func == FN_DIAG) || do_reset;
         tx_flush_ff   <= (take_cmd && wr_func == FN_DIAG) || do_reset
                          || (exec_fin && (func_ff == FN_SET_SRC_INS
                                           || func_ff == FN_CLR_SRC_INS));
         diag_start_ff <= take_cmd && wr_func == FN_DIAG;
         tx_send_ff    <= exec_fin && func_ff == FN_TX_SEND && online_ff;
         crc_byp_ff    <= loop_mod_ff | loop_int_ff;
      end
   end

   // read mux
   wire [31:0] rd_csr  = {24'h0, done_ff, 3'h0, status_ff};
   wire [31:0] rd_mode = {24'h0, (state_ff == ST_DIAG), indic_ff, loop_int_ff,
                          loop_mod_ff, src_ins_ff, online_ff, rx_err_ff, promisc_ff};
   wire [31:0] rd_link = {30'h0, rx_busy_s2_ff, off_pend_ff};
   wire [31:0] rd_diag = {28'h0, diag_code_ff};
   wire [31:0] rd_mux  = hit_csr  ? rd_csr  :
                         hit_mode ? rd_mode :
                         hit_link ? rd_link :
                         hit_diag ? rd_diag : 32'h0000_0000;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_ff  <= 32'h0000_0000;
         pslverr_ff <= 1'b0;
      end else begin
         prdata_ff  <= (psel && !penable && !pwrite) ? rd_mux : prdata_ff;
         pslverr_ff <= psel && !penable && !mapped;
      end
   end

   assign prdata              = prdata_ff;
   assign pready              = 1'b1;
   assign pslverr             = pslverr_ff;
   assign promisc_mode        = promisc_ff;     // own frames, no CRC check
   assign rx_err_accept       = rx_err_ff;      // filter stays, count kept
   assign online              = online_ff;
   assign src_insert          = src_ins_ff;
   assign crc_gen_bypass      = crc_byp_ff;
   assign self_test_indicator = indic_ff;
   assign rx_flush            = rx_flush_ff;
   assign tx_flush            = tx_flush_ff;
   assign diag_start          = diag_start_ff;
   assign tx_send_start       = tx_send_ff;

endmodule

/* File: bench/lan_mode_chk.sv */
/*
 * lan_mode_chk: concurrent checks on the mode-command decoder ports.
 * assumes: bound to the decoder; host waits for done except on Reset.
 */
`timescale 1ns/1ps

module lan_mode_chk
   import lan_cmd_pkg::*;
(
   // apb
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0]  pstrb,
   // datapath and modes
   input wire logic        rx_frame_busy,
   input wire logic        promisc_mode,
   input wire logic        rx_err_accept,
   input wire logic        online,
   input wire logic        src_insert,
   input wire logic        crc_gen_bypass,
   input wire logic        self_test_indicator,
   input wire logic        rx_flush,
   input wire logic        tx_flush,
   input wire logic        diag_start,
   input wire logic        tx_send_start
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   wire       wr_csr = psel && penable && pwrite && paddr == CTRL_STATUS_OFF && pstrb[1];
   wire [5:0] func   = pwdata[FUNC_LSB +: FUNC_W];

   sequence s_cmd(logic [5:0] c);
      wr_csr && func == c;
   endsequence

   a_promisc_set: assert property (s_cmd(FN_SET_PROMISC) |-> ##[1:3] promisc_mode)
      else $error("promiscuous mode not entered");
   a_promisc_clr: assert property (s_cmd(FN_CLR_PROMISC) |-> ##[1:3] !promisc_mode)
      else $error("promiscuous mode not left");
   a_rxerr_set: assert property (s_cmd(FN_SET_RX_ERR) |-> ##[1:3] rx_err_accept)
      else $error("receive-on-error not set");
   a_rxerr_clr: assert property (s_cmd(FN_CLR_RX_ERR) |-> ##[1:3] !rx_err_accept)
      else $error("receive-on-error not cleared");
   a_online_set: assert property (s_cmd(FN_ONLINE) |-> ##[1:3] online ##0 !self_test_indicator)
      else $error("online or indicator wrong");
   a_src_ins_off: assert property (s_cmd(FN_CLR_SRC_INS) |-> ##[1:3] tx_flush ##[0:2] !src_insert)
      else $error("insertion off without flush");
   a_diag_ind: assert property (diag_start |-> ##[0:2] self_test_indicator && src_insert)
      else $error("indicator or defaults wrong at diag");
   a_offline_hold: assert property ($fell(online) |-> !$past(rx_frame_busy, 2))
      else $error("offline cut a frame");
   a_tx_online: assert property (tx_send_start |-> online)
      else $error("transmit started while offline");
   a_loop_crc: assert property (s_cmd(FN_SET_LOOP_MOD) |-> ##[1:3] crc_gen_bypass)
      else $error("crc not bypassed in loopback");
   a_reset_cmd: assert property (s_cmd(FN_RESET) |-> ##[1:3]
      (src_insert && !promisc_mode && !rx_err_accept && !online))
      else $error("reset command left modes");
   a_diag_flush: assert property (diag_start |-> rx_flush && tx_flush)
      else $error("memories not flushed at diag start");
   a_tx_send: assert property (s_cmd(FN_TX_SEND) ##0 online |-> ##[1:3] tx_send_start)
      else $error("online transmit not started");
   a_promisc_keep: assert property (s_cmd(FN_CLR_PROMISC) |-> ##1 !rx_flush ##1 !rx_flush ##1 !rx_flush)
      else $error("receive memory flushed on promiscuous clear");
endmodule

/* File: bench/lan_datapath_model.sv */
/*
 * lan_datapath_model: receive frame and self-test engine beside the decoder.
 * assumes: frame_go pulses start a frame; diag_sel picks the result code.
 */
`timescale 1ns/1ps

module lan_datapath_model (
   // clock
   input wire logic       pclk,
   input wire logic       presetn,
   // control
   input wire logic       frame_go,
   input wire logic       diag_start,
   input wire logic [3:0] diag_sel,
   // status
   output logic           rx_frame_busy,
   output logic           diag_done,
   output logic [3:0]     diag_code
);
   int busy_cnt;
   int diag_cnt;

   // code is only valid with done; otherwise an inverted pattern
   assign diag_code = diag_done ? diag_sel : ~diag_sel;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         busy_cnt <= 0;
         diag_cnt <= 0;
         rx_frame_busy <= 1'b0;
         diag_done <= 1'b0;
      end else begin
         if (frame_go) busy_cnt <= 50;
         else if (busy_cnt > 0) busy_cnt <= busy_cnt - 1;
         rx_frame_busy <= frame_go || busy_cnt > 1;
         if (diag_start) begin
            diag_cnt <= 300;
            diag_done <= 1'b0;
         end else if (diag_cnt > 0) begin
            diag_cnt <= diag_cnt - 1;
            diag_done <= diag_cnt == 1;
         end
      end
   end
endmodule

/* File: bench/tb_lan_mode_command_decoder.sv */
/*
 * tb_lan_mode_command_decoder: APB-driven command sequences with checks.
 * assumes: zero-wait APB slave; datapath model stands in for the far side.
 */
`timescale 1ns/1ps

module tb_lan_mode_command_decoder;
   import lan_cmd_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, frame_go;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, d;
   logic [3:0] pstrb, diag_sel, diag_code;
   logic perr;
   logic rx_frame_busy, diag_done, promisc_mode, rx_err_accept, online, src_insert;
   logic crc_gen_bypass, self_test_indicator, rx_flush, tx_flush, diag_start, tx_send_start;
   int miscompares = 0;
   int n_tests = 0;

   lan_mode_command_decoder u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_frame_busy(rx_frame_busy),
      .diag_done(diag_done), .diag_code(diag_code), .promisc_mode(promisc_mode),
      .rx_err_accept(rx_err_accept), .online(online), .src_insert(src_insert),
      .crc_gen_bypass(crc_gen_bypass), .self_test_indicator(self_test_indicator),
      .rx_flush(rx_flush), .tx_flush(tx_flush), .diag_start(diag_start),
      .tx_send_start(tx_send_start));
   lan_datapath_model u_dp (.pclk(pclk), .presetn(presetn), .frame_go(frame_go),
      .diag_start(diag_start), .diag_sel(diag_sel), .rx_frame_busy(rx_frame_busy),
      .diag_done(diag_done), .diag_code(diag_code));

   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   task summarize;
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      d = prdata;
      perr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task issue(input logic [5:0] f);
      apb(1'b1, CTRL_STATUS_OFF, {18'h0, f, 8'h00});
   endtask

   // poll the control_status_word; the read also clears done
   task wait_done(input logic [3:0] st);
      for (int i = 0; i < 1000; i++) begin
         apb(1'b0, CTRL_STATUS_OFF, 32'h0);
         if (d[DONE_BIT] === 1'b1) break;
      end
      chk("done", d[DONE_BIT], 1'b1);
      chk("status", d[3:0], st);
   endtask

   task mode(input logic [31:0] exp);
      apb(1'b0, MODE_OFF, 32'h0);
      chk("mode", d & 32'h4F, exp);
   endtask

   task cmd(input logic [5:0] f, input logic [3:0] st, input logic [31:0] m);
      issue(f);
      wait_done(st);
      mode(m);
   endtask

   initial begin
      repeat (20000) @(posedge pclk);
      miscompares++;
      summarize();
   end

   initial begin
      {psel, penable, pwrite, frame_go} = 4'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
      pstrb = 4'hF;
      diag_sel = 4'h0;
      presetn = 1'b0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      mode(32'h08);
      cmd(FN_SET_PROMISC, ST_OK, 32'h09);
      cmd(FN_SET_RX_ERR, ST_OK, 32'h0B);
      cmd(FN_CLR_PROMISC, ST_OK, 32'h0A);
      cmd(FN_CLR_RX_ERR, ST_OK, 32'h08);
      cmd(FN_ONLINE, ST_OK, 32'h0C);
      cmd(FN_CLR_SRC_INS, ST_OK, 32'h04);
      cmd(FN_SET_SRC_INS, ST_OK, 32'h0C);
      cmd(FN_TX_SEND, ST_OK, 32'h0C);
      cmd(FN_RSVD_A, ST_OK, 32'h0C);
      cmd(FN_RSVD_B, ST_OK, 32'h0C);
      cmd(6'o00, ST_ILLEGAL, 32'h0C);
      // go offline while a frame is arriving
      @(posedge pclk);
      frame_go <= 1'b1;
      @(posedge pclk);
      frame_go <= 1'b0;
      issue(FN_OFFLINE);
      repeat (10) @(posedge pclk);
      chk("online mid-frame", online, 1'b1);
      wait_done(ST_OK);
      repeat (50) @(posedge pclk);
      mode(32'h08);
      cmd(FN_TX_SEND, ST_INAPPROP, 32'h08);
      cmd(FN_SET_LOOP_MOD, ST_OK, 32'h08);
      chk("crc bypass", crc_gen_bypass, 1'b1);
      cmd(FN_SET_LOOP_INT, ST_OK, 32'h48);
      cmd(FN_CLR_LOOP, ST_OK, 32'h08);
      chk("crc bypass off", crc_gen_bypass, 1'b0);
      // diagnostics pass, then fail
      cmd(FN_SET_PROMISC, ST_OK, 32'h09);
      issue(FN_DIAG);
      repeat (10) @(posedge pclk);
      chk("indicator in diag", self_test_indicator, 1'b1);
      wait_done(ST_OK);
      mode(32'h08);
      diag_sel <= 4'h2;
      cmd(FN_DIAG, 4'h2, 32'h48);
      cmd(FN_RESET, ST_OK, 32'h08);
      // reset issued while a command is still running
      issue(FN_DIAG);
      issue(FN_RESET);
      wait_done(ST_OK);
      repeat (5) @(posedge pclk);
      mode(32'h08);
      apb(1'b0, 8'h10, 32'h0);
      chk("unmapped data", d, 32'h0);
      chk("unmapped err", perr, 1'b1);
      summarize();
   end
endmodule

bind lan_mode_command_decoder lan_mode_chk u_chk (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .pstrb(pstrb), .rx_frame_busy(rx_frame_busy), .promisc_mode(promisc_mode),
   .rx_err_accept(rx_err_accept), .online(online), .src_insert(src_insert),
   .crc_gen_bypass(crc_gen_bypass), .self_test_indicator(self_test_indicator),
   .rx_flush(rx_flush), .tx_flush(tx_flush), .diag_start(diag_start),
   .tx_send_start(tx_send_start));
